// >>> verilog/tmcc_core.v
// Operation
// [R1] Count-up counter compared against preset values; match raises interrupt.
// [R2] Match may clear the counter and change the output pin.
// [R3] Three-bit select picks system ratio, high clock, sub clock or pin.
// [R4] Separate interrupt pulses for comparator A and comparator P matches.
// [R5] One event input pin and one output pin per timer.
// [R6] Pin counting uses only the selected rising or falling edge.
// [R7] Event pin also triggers single pulse mode on larger types.
// [R8] Compare output mode drives pin high, low or toggles on match.
// [R9] Output pin carries the PWM waveform in PWM mode.
// [R10] Edge aligned PWM; period or duty adjustable, not both.
// [R11] One compact, one standard, two periodic instances exist.
// [R12] Counter and compares split; low bytes via shared 8-bit buffer.
// [R13] Buffer moves only on high byte access, never low alone.
// [R14] Software uses plain moves and prescribed order for compare lows.
// [R15] Write low first into buffer; high write commits both bytes.
// [R16] Read high first latching low; low read returns buffer.
// [R17] Event input synchronised and edge detected before counting.
`include "tmcc_defines.vh"
`default_nettype none
module tmcc_core (
    input  wire        I_REF_CLK,
    input  wire        I_RST_B,
    input  wire        I_TIMER_ON,
    input  wire        I_PAUSE,
    input  wire [2:0]  I_CLOCK_SOURCE_SELECT,
    input  wire [1:0]  I_MODE,
    input  wire [1:0]  I_IO_SEL,
    input  wire        I_OUT_CTRL,
    input  wire        I_CCLR_A,
    input  wire        I_PERIOD_ADJ,
    input  wire        I_FH_TICK,
    input  wire        I_FSUB_TICK,
    input  wire        I_TIMER_EVENT_INPUT,
    input  wire        I_WR,
    input  wire        I_RD,
    input  wire [1:0]  I_SEL,
    input  wire        I_HIGH,
    input  wire [7:0]  I_WDATA,
    output reg  [7:0]  O_RDATA,
    output reg         O_TIMER_OUTPUT_PIN,
    output reg         O_IRQ_A,
    output reg         O_IRQ_P,
    output wire        O_TRIGGER
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [15:0] cnt_q;
    reg  [15:0] cmpa_q;
    reg  [15:0] cmpp_q;
    reg  [7:0]  buf_q;
    reg  [7:0]  div_sys_q;
    reg  [7:0]  div_h_q;
    reg         on_q;
    wire        pin_rise;
    wire        pin_fall;
    reg         tick;
    wire        run;
    wire        match_a;
    wire        match_p;
    wire        clr_on_p;
    wire        clr_on_a;
    wire        pwm_wrap;
    wire [15:0] period_val;
    wire [15:0] duty_val;
    wire        pwm_active;

    // ****************************************************************
    // Event pin conditioning
    // ****************************************************************
    // Pin crosses into the system clock before any edge logic
    tmcc_edge_sync u_sync ( // [R17]
        .i_clk   (I_REF_CLK),
        .i_rst_b (I_RST_B),
        .i_async (I_TIMER_EVENT_INPUT), // [R5]
        .o_rise  (pin_rise),
        .o_fall  (pin_fall)
    );

    // Trigger for single pulse logic of the larger timer types
    assign O_TRIGGER = pin_rise; // [R7]

    // ****************************************************************
    // Prescalers
    // ****************************************************************
    // Free running dividers; a tick is one cycle wide
    always @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            div_sys_q <= 8'h00;
            div_h_q   <= 8'h00;
        end else begin
            div_sys_q <= (div_sys_q == `TMCC_DIV4) ? 8'h00
                                                   : div_sys_q + 8'h01;
            if (I_FH_TICK) begin
                div_h_q <= div_h_q + 8'h01;
            end
        end
    end

    // Clock source multiplexer
    always @* begin
        case (I_CLOCK_SOURCE_SELECT) // [R3]
            `TMCC_CK_SYS_DIV4: tick = (div_sys_q == `TMCC_DIV4);
            `TMCC_CK_SYS:      tick = 1'b1;
            `TMCC_CK_H_DIV16:  tick = I_FH_TICK &
                                      ((div_h_q & `TMCC_DIV16) == `TMCC_DIV16);
            `TMCC_CK_H_DIV64:  tick = I_FH_TICK &
                                      ((div_h_q & `TMCC_DIV64) == `TMCC_DIV64);
            `TMCC_CK_SUB_A,
            `TMCC_CK_SUB_B:    tick = I_FSUB_TICK;
            `TMCC_CK_PIN_RISE: tick = pin_rise; // [R6]
            default:           tick = pin_fall; // [R6]
        endcase
    end

    // ****************************************************************
    // Counter and comparators
    // ****************************************************************
    // Held off on the turn-on edge: a stale count must not match there
    assign run = I_TIMER_ON & on_q & ~I_PAUSE & tick;

    // Edge aligned PWM: P sets period or duty, A the other one
    assign period_val = I_PERIOD_ADJ ? cmpa_q : cmpp_q; // [R10]
    assign duty_val   = I_PERIOD_ADJ ? cmpp_q : cmpa_q; // [R10]

    // Matches only count when the counter really advances onto them
    assign match_a = run & (cnt_q + 16'h0001 == cmpa_q); // [R1]
    assign match_p = run & (cnt_q + 16'h0001 == cmpp_q); // [R1]

    // PWM wraps on its period; other modes clear on the chosen comparator
    assign pwm_wrap = run & (cnt_q + 16'h0001 == period_val);
    assign clr_on_a = match_a & I_CCLR_A;
    assign clr_on_p = match_p & ~I_CCLR_A;

    // Counter clears on turn-on edge; retains value while off or paused
    always @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            cnt_q <= 16'h0000;
            on_q  <= 1'b0;
        end else begin
            on_q <= I_TIMER_ON;
            if (I_TIMER_ON & ~on_q) begin
                cnt_q <= 16'h0000;
            end else if (I_MODE == `TMCC_MODE_PWM && pwm_wrap) begin
                cnt_q <= 16'h0000; // [R2]
            end else if (I_MODE != `TMCC_MODE_PWM &&
                         (clr_on_a | clr_on_p)) begin
                cnt_q <= 16'h0000; // [R2]
            end else if (run) begin
                cnt_q <= cnt_q + 16'h0001; // [R1]
            end
        end
    end

    // Interrupt pulses, one per comparator
    always @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_IRQ_A <= 1'b0;
            O_IRQ_P <= 1'b0;
        end else begin
            O_IRQ_A <= match_a; // [R4]
            O_IRQ_P <= match_p; // [R4]
        end
    end

    // ****************************************************************
    // Output pin
    // ****************************************************************
    // Active while count below duty, from start of each period
    assign pwm_active = (cnt_q < duty_val); // [R10]

    always @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_TIMER_OUTPUT_PIN <= 1'b0;
        end else if (I_TIMER_ON & ~on_q) begin
            // Restart returns the pin to its initial level
            O_TIMER_OUTPUT_PIN <= I_OUT_CTRL;
        end else if (I_MODE == `TMCC_MODE_CMP) begin
            if (match_a) begin
                case (I_IO_SEL) // [R8]
                    `TMCC_IO_LOW:    O_TIMER_OUTPUT_PIN <= 1'b0;
                    `TMCC_IO_HIGH:   O_TIMER_OUTPUT_PIN <= 1'b1;
                    `TMCC_IO_TOGGLE: O_TIMER_OUTPUT_PIN <= ~O_TIMER_OUTPUT_PIN;
                    default:         O_TIMER_OUTPUT_PIN <= O_TIMER_OUTPUT_PIN;
                endcase
            end
        end else if (I_MODE == `TMCC_MODE_PWM) begin
            // Polarity from output control: high means active high
            case (I_IO_SEL) // [R9]
                2'h0:    O_TIMER_OUTPUT_PIN <= ~I_OUT_CTRL;
                2'h1:    O_TIMER_OUTPUT_PIN <= I_OUT_CTRL;
                2'h2:    O_TIMER_OUTPUT_PIN <= ~(pwm_active ^ I_OUT_CTRL);
                default: O_TIMER_OUTPUT_PIN <= O_TIMER_OUTPUT_PIN;
            endcase
        end
    end

    // ****************************************************************
    // Byte access with shared low-byte buffer
    // ****************************************************************
    // Low writes only fill the buffer; high write commits both bytes.
    // Software must follow low-then-high order or values are undefined.
    always @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            cmpa_q <= `TMCC_CMP_RST;
            cmpp_q <= `TMCC_CMP_RST;
            buf_q  <= 8'h00;
        end else if (I_WR) begin
            if (!I_HIGH) begin
                buf_q <= I_WDATA; // [R15] [R12]
            end else if (I_SEL == `TMCC_SEL_CMPA) begin
                cmpa_q <= {I_WDATA, buf_q}; // [R13] [R15]
            end else if (I_SEL == `TMCC_SEL_CMPP) begin
                cmpp_q <= {I_WDATA, buf_q}; // [R13] [R15]
            end
        end else if (I_RD & I_HIGH) begin
            // High read snapshots the low byte for the next low read
            if (I_SEL == `TMCC_SEL_CNT) begin
                buf_q <= cnt_q[7:0]; // [R16]
            end else if (I_SEL == `TMCC_SEL_CMPA) begin
                buf_q <= cmpa_q[7:0]; // [R16]
            end else begin
                buf_q <= cmpp_q[7:0]; // [R16]
            end
        end
    end

    // Read data registered; low reads always return the buffer
    always @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_RDATA <= 8'h00;
        end else if (I_RD) begin
            if (!I_HIGH) begin
                O_RDATA <= buf_q; // [R13]
            end else if (I_SEL == `TMCC_SEL_CNT) begin
                O_RDATA <= cnt_q[15:8]; // [R12]
            end else if (I_SEL == `TMCC_SEL_CMPA) begin
                O_RDATA <= cmpa_q[15:8];
            end else begin
                O_RDATA <= cmpp_q[15:8];
            end
        end
    end
    // Instance count per device is set where cores are placed. [R11]
endmodule // tmcc_core
`default_nettype wire

// >>> verilog/tmcc_defines.vh
`ifndef TMCC_DEFINES_VH
`define TMCC_DEFINES_VH
// Clock select codes
`define TMCC_CK_SYS_DIV4   3'h0
`define TMCC_CK_SYS        3'h1
`define TMCC_CK_H_DIV16    3'h2
`define TMCC_CK_H_DIV64    3'h3
`define TMCC_CK_SUB_A      3'h4
`define TMCC_CK_SUB_B      3'h5
`define TMCC_CK_PIN_RISE   3'h6
`define TMCC_CK_PIN_FALL   3'h7
// Operating modes
`define TMCC_MODE_CMP      2'h0
`define TMCC_MODE_PWM      2'h2
`define TMCC_MODE_TIMER    2'h3
// Output action codes
`define TMCC_IO_NONE       2'h0
`define TMCC_IO_LOW        2'h1
`define TMCC_IO_HIGH       2'h2
`define TMCC_IO_TOGGLE     2'h3
// Register selects for the byte access port
`define TMCC_SEL_CNT       2'h0
`define TMCC_SEL_CMPA      2'h1
`define TMCC_SEL_CMPP      2'h2
// Prescale divide counts
`define TMCC_DIV4          8'h03
`define TMCC_DIV16         8'h0f
`define TMCC_DIV64         8'h3f
// Reset values
`define TMCC_CMP_RST       16'h0000
`endif

// >>> verilog/tmcc_edge_sync.v
`default_nettype none
// Two-flop synchroniser with rising and falling edge pulses
module tmcc_edge_sync (
    input  wire i_clk,
    input  wire i_rst_b,
    input  wire i_async,
    output reg  o_rise,
    output reg  o_fall
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    // First flop feeds only the second flop
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
            prev_q <= sync_q;
            o_rise <= sync_q & ~prev_q;
            o_fall <= ~sync_q & prev_q;
        end
    end
endmodule // tmcc_edge_sync
`default_nettype wire

// >>> test/tmcc_core_chk.sv
`include "tmcc_defines.vh"
`default_nettype none
// ****************************************
// Port checker for the timer core
// ****************************************
module tmcc_core_chk (
    input wire logic       I_REF_CLK,
    input wire logic       I_RST_B,
    input wire logic       I_TIMER_ON,
    input wire logic       I_PAUSE,
    input wire logic [1:0] I_MODE,
    input wire logic [1:0] I_IO_SEL,
    input wire logic       I_OUT_CTRL,
    input wire logic       I_TIMER_EVENT_INPUT,
    input wire logic       I_RD,
    input wire logic [7:0] O_RDATA,
    input wire logic       O_TIMER_OUTPUT_PIN,
    input wire logic       O_IRQ_A,
    input wire logic       O_IRQ_P,
    input wire logic       O_TRIGGER
);
    timeunit 1ns;
    timeprecision 1ps;
    // One domain, so clock and reset are given once
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B);
    a_reset_quiet: assert property ($rose(I_RST_B) |-> !O_IRQ_A && !O_IRQ_P
        && !O_TRIGGER && O_RDATA == 8'h00 && !O_TIMER_OUTPUT_PIN)
        else $error("outputs not idle after reset");
    a_irq_a_run: assert property (O_IRQ_A |-> $past(I_TIMER_ON && !I_PAUSE))
        else $error("match A while counter stopped");
    a_irq_p_run: assert property (O_IRQ_P |-> $past(I_TIMER_ON && !I_PAUSE))
        else $error("match P while counter stopped");
    a_rdata_hold: assert property (!$past(I_RD) |-> $stable(O_RDATA))
        else $error("read data moved without a read");
    a_trig_pulse: assert property (O_TRIGGER |=> !O_TRIGGER)
        else $error("trigger longer than one cycle");
    a_trig_cause: assert property (O_TRIGGER |-> $past(I_TIMER_EVENT_INPUT, 3)
        || $past(I_TIMER_EVENT_INPUT, 4))
        else $error("trigger without a synchronised rise");
    a_start_level: assert property (I_MODE == `TMCC_MODE_CMP
        && $rose(I_TIMER_ON) |=> O_TIMER_OUTPUT_PIN == $past(I_OUT_CTRL))
        else $error("pin not at initial level after start");
    // Excludes the start edge, where the pin is reloaded instead
    a_toggle_match: assert property (I_MODE == `TMCC_MODE_CMP
        && I_IO_SEL == `TMCC_IO_TOGGLE && I_TIMER_ON && $past(I_TIMER_ON, 2)
        && $changed(O_TIMER_OUTPUT_PIN) |-> O_IRQ_A || $past(O_IRQ_A))
        else $error("pin changed without a match");
endmodule // tmcc_core_chk
bind tmcc_core tmcc_core_chk tmcc_core_chk_i (.I_REF_CLK(I_REF_CLK),
    .I_RST_B(I_RST_B), .I_TIMER_ON(I_TIMER_ON), .I_PAUSE(I_PAUSE),
    .I_MODE(I_MODE), .I_IO_SEL(I_IO_SEL), .I_OUT_CTRL(I_OUT_CTRL),
    .I_TIMER_EVENT_INPUT(I_TIMER_EVENT_INPUT), .I_RD(I_RD),
    .O_RDATA(O_RDATA), .O_TIMER_OUTPUT_PIN(O_TIMER_OUTPUT_PIN),
    .O_IRQ_A(O_IRQ_A), .O_IRQ_P(O_IRQ_P), .O_TRIGGER(O_TRIGGER));
`default_nettype wire

// >>> test/tmcc_evt_src.sv
`default_nettype none
// ****************************************
// External event source on the timer input
// ****************************************
module tmcc_evt_src (
    input  wire logic       i_clk,
    input  wire logic       i_run,
    input  wire logic [3:0] i_half,
    output var  logic       o_evt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q = 4'h0;
    initial o_evt = 1'b0;
    // Square wave, half period i_half+1; holds its level when stopped
    always @(negedge i_clk) begin
        cnt_q <= (i_run && cnt_q != i_half) ? cnt_q + 4'h1 : 4'h0;
        if (i_run && cnt_q == i_half)
            o_evt <= ~o_evt;
    end
endmodule // tmcc_evt_src
`default_nettype wire

// >>> test/tb.sv
`include "tmcc_defines.vh"
`default_nettype none
// ****************************************
// Self-checking bench for the timer core
// ****************************************
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_b, on, pau, oc, ca, padj, fh, fs, wr, rd, hi;
    logic        run, evt, evl, pin, ia, ip, trg, pend;
    logic [2:0]  cks;
    logic [1:0]  md, io, sel;
    logic [3:0]  half;
    logic [7:0]  wd, rdat;
    logic [15:0] v, p, d;
    int          failures = 0, num_checks = 0, na, np, nt, ne, hc, h0;
    logic [7:0]  expq[$];
    tmcc_core tmcc_core_i (.I_REF_CLK(clk), .I_RST_B(rst_b),
        .I_TIMER_ON(on), .I_PAUSE(pau), .I_CLOCK_SOURCE_SELECT(cks),
        .I_MODE(md), .I_IO_SEL(io), .I_OUT_CTRL(oc), .I_CCLR_A(ca),
        .I_PERIOD_ADJ(padj), .I_FH_TICK(fh), .I_FSUB_TICK(fs),
        .I_TIMER_EVENT_INPUT(evt), .I_WR(wr), .I_RD(rd), .I_SEL(sel),
        .I_HIGH(hi), .I_WDATA(wd), .O_RDATA(rdat), .O_TIMER_OUTPUT_PIN(pin),
        .O_IRQ_A(ia), .O_IRQ_P(ip), .O_TRIGGER(trg));
    tmcc_evt_src tmcc_evt_src_i (.i_clk(clk), .i_run(run), .i_half(half),
        .o_evt(evt));
    initial clk = 1'b0;
    always #5 clk = ~clk;
    // Read answers show one edge after the strobe; compare on the fall
    always @(posedge clk) pend <= rd & ~wr;
    always @(negedge clk) if (pend === 1'b1) chk(rdat, expq.pop_front());
    // Event tallies, cleared whenever the timer is off
    always @(negedge clk) begin
        na <= on ? na + int'(ia === 1'b1) : 0;
        np <= on ? np + int'(ip === 1'b1) : 0;
        nt <= on ? nt + int'(trg === 1'b1) : 0;
        hc <= on ? hc + int'(pin === 1'b1) : 0;
        fh <= 1'($urandom);
        fs <= 1'($urandom);
    end
    always @(posedge clk) begin
        evl <= evt;
        ne <= on ? ne + int'(evt !== evl && evt === ~cks[0]) : 0;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Byte access: strobe for one edge, then a quiet edge
    task automatic acc(input logic w, input logic [1:0] s, input logic h,
                       input logic [7:0] dat);
        @(negedge clk);
        wr = w;
        rd = ~w;
        sel = s;
        hi = h;
        wd = dat;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
    endtask
    task automatic w16(input logic [1:0] s, input logic [15:0] x);
        acc(1'b1, s, 1'b0, x[7:0]);
        acc(1'b1, s, 1'b1, x[15:8]);
    endtask
    task automatic r16(input logic [1:0] s, input logic [15:0] x);
        expq.push_back(x[15:8]);
        acc(1'b0, s, 1'b1, 8'h00);
        expq.push_back(x[7:0]);
        acc(1'b0, s, 1'b0, 8'h00);
    endtask
    task automatic final_report;
        if (failures == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #500000;
        failures++;
        final_report();
    end
    initial begin
        void'($urandom(6037));
        {rst_b, on, pau, oc, ca, padj, wr, rd, hi, run, evl, pend} = '0;
        {cks, md, io, sel, wd} = '0;
        half = 4'h3;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        r16(`TMCC_SEL_CNT, 16'h0000);
        r16(`TMCC_SEL_CMPA, `TMCC_CMP_RST);
        // Pairs through the shared buffer; a lone low write changes only the buffer
        for (int s = 1; s < 3; s++) begin
            v = 16'($urandom);
            w16(2'(s), v);
            r16(2'(s), v);
            acc(1'b1, 2'(s), 1'b0, ~v[7:0]);
            r16(2'(s), v);
        end
        // Compare output actions: none (P clears), low, high, toggle
        cks = `TMCC_CK_SYS;
        for (int k = 0; k < 4; k++) begin
            v = 16'(8 + $urandom % 8);
            io = 2'(k);
            ca = (k != 0);
            oc = (k == 1) ? 1'b1 : (k == 2) ? 1'b0 : 1'($urandom);
            w16(`TMCC_SEL_CMPA, ca ? v : 16'hffff);
            w16(`TMCC_SEL_CMPP, ca ? 16'hffff : v);
            on = 1'b1;
            repeat (3 * v + v / 2) @(negedge clk);
            chk(8'(na), ca ? 8'h03 : 8'h00);
            chk(8'(np), ca ? 8'h00 : 8'h03);
            chk({7'h0, pin}, {7'h0, k == 0 ? oc : k == 3 ? ~oc : k == 2});
            on = 1'b0;
        end
        // Event counting on each selected pin edge, at a random event rate
        md = `TMCC_MODE_TIMER;
        // Keep comparator A out of reach so no match clears the count
        w16(`TMCC_SEL_CMPA, 16'hffff);
        for (int k = 6; k < 8; k++) begin
            cks = 3'(k);
            half = 4'(1 + $urandom % 8);
            on = 1'b1;
            run = 1'b1;
            repeat (60) @(negedge clk);
            run = 1'b0;
            repeat (8) @(negedge clk);
            v = 16'(ne);
            if (k == 6)
                chk(8'(nt), 8'(ne));
            on = 1'b0;
            r16(`TMCC_SEL_CNT, v);
        end
        // Pause freezes the count at its residual value
        cks = `TMCC_CK_SYS;
        v = 16'(5 + $urandom % 20);
        on = 1'b1;
        repeat (v) @(negedge clk);
        pau = 1'b1;
        repeat (6) @(negedge clk);
        on = 1'b0;
        pau = 1'b0;
        r16(`TMCC_SEL_CNT, v - 16'h0001);
        // Edge-aligned PWM, period on one comparator and duty on the other
        {md, io, oc, cks} = {`TMCC_MODE_PWM, `TMCC_IO_TOGGLE - 2'h1, 1'b1, 3'h1};
        for (int k = 0; k < 2; k++) begin
            padj = 1'(k);
            p = 16'(10 + $urandom % 6);
            d = 16'(2 + $urandom % 6);
            w16(`TMCC_SEL_CMPA, padj ? p : d);
            w16(`TMCC_SEL_CMPP, padj ? d : p);
            on = 1'b1;
            repeat (2 * p) @(negedge clk);
            h0 = hc;
            repeat (4 * p) @(negedge clk);
            chk(8'(hc - h0), 8'(4 * d));
            on = 1'b0;
        end
        repeat (4) @(negedge clk);
        final_report();
    end
endmodule // tb
`default_nettype wire
